// ### inc/voice_flow_consts.svh
// Weight, timing, saturation and FIFO constants for the voice flow block
`ifndef VOICE_FLOW_CONSTS_SVH
`define VOICE_FLOW_CONSTS_SVH
`define W_UNITY 16'h7FFF
`define W_OFF 16'h0000
`define FRAME_LEN_FORCED 9'h0C0
`define SAMPLE_MAX 16'h7FFF
`define SAMPLE_MIN 16'h8000
`define FIFO_DEPTH 4
`endif

// ### inc/voice_flow_pkg.sv
// Types shared by the voice flow block
package voice_flow_pkg;
    typedef enum logic [3:0] {
        MODE_STD = 4'h1,
        MODE_LEGACY = 4'h2,
        MODE_STANDALONE = 4'h4,
        MODE_TEST = 4'h8
    } op_mode_t;
    // Mixer port indices; the packet router uses route_src_t codes
    typedef enum logic [2:0] {
        P_ANALOG = 3'h0,
        P_PCM = 3'h1,
        P_VOC = 3'h2,
        P_TONE = 3'h3,
        P_COMM = 3'h4
    } mix_port_t;
    // Packet router source select: off or one of three inputs
    typedef enum logic [1:0] {
        RT_OFF = 2'h0,
        RT_VOC = 2'h1,
        RT_LINK = 2'h2,
        RT_COMM = 2'h3
    } route_src_t;
endpackage : voice_flow_pkg

// ### hw/sample_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("sample_fifo depth must be a power of two, 2 or more");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire logic [AW:0] fill = wr_ptr - rd_ptr;
    wire logic full = (fill == (AW+1)'(DEPTH));
    wire logic empty = (fill == '0);
    wire logic do_wr = ce && in_valid && !full;
    wire logic do_rd = ce && out_ready && !empty;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr[AW-1:0]];
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_wr)
                wr_ptr <= wr_ptr + 1'b1;
            if (do_rd)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (do_wr)
            mem[wr_ptr[AW-1:0]] <= in_data;
    end
    fifo_bound_a: assert property (@(posedge clk_sys) disable iff (rst)
        fill <= (AW+1)'(DEPTH))
        else $error("fifo fill beyond depth");
endmodule : sample_fifo
`default_nettype wire

// ### hw/voice_mode_mixer_router.sv
// Mode selector, five-port weighted mixer, packet router, control capture
// ****************************************************************
// Summary of operation
// ****************************************************************
// Summary of operation
// - Exactly four modes, differing in routing/control
// - Both mode switches off selects standard mode
// - Standard mode takes all stored settings
// - Legacy mode forces values over stored ones
// - Legacy, switch off: analog-vocoder unity, fixed routes
// - Legacy, switch on: PCM replaces analog paths
// - Standalone: analog-vocoder unity, packets looped back
// - Standalone: truncate line change toggles timing
// - Test mode ignores external vocoder control lines
// - Capture on frame marker, apply next task
// - Terminal control values take effect at once
// - Vector-exact test stops active vocoder control
// - Five ports, each output from others
// - Output is saturated sum of weighted inputs
// - Weights Q1.15: zero off, 7FFF unity
// - Tone port output exists, drives nothing
// - Directions are referenced at the mixer
// - Each router output has one source
`timescale 1ns/1ps
`default_nettype none
`include "voice_flow_consts.svh"
module voice_mode_mixer_router
    import voice_flow_pkg::*;
#(
    parameter int SW = 16,
    parameter int PW = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic mode_select_switch_a,
    input wire logic mode_select_switch_b,
    input wire logic linear_port_select_switch,
    input wire logic truncate_switch,
    // Stored parameter block: 25 weights [out*5+in], 3 routes, timing
    input wire logic [25*16-1:0] stored_weights,
    input wire logic [5:0] stored_routes,
    input wire logic stored_rate_converter_enable,
    input wire logic stored_linear_timing_source,
    input wire logic [8:0] stored_frame_length_standard_mode,
    input wire logic [8:0] stored_frame_length_trunc,
    // Mixer sample inputs, one per port, received at the mixer
    input wire logic [5*16-1:0] mix_rx,
    input wire logic sample_strobe,
    output logic [5*16-1:0] mix_tx,
    output logic mix_valid,
    // Analog output passes the FIFO to the codec side
    output logic analog_out_valid,
    input wire logic analog_out_ready,
    output logic [15:0] analog_out_data,
    output logic analog_fifo_ready,
    // Packet router: vocoder, link, comm inputs
    input wire logic [PW-1:0] pkt_in_voc,
    input wire logic [PW-1:0] pkt_in_link,
    input wire logic [PW-1:0] pkt_in_comm,
    output logic [PW-1:0] pkt_out_voc,
    output logic [PW-1:0] pkt_out_link,
    output logic [PW-1:0] pkt_out_comm,
    // Vocoder control
    input wire logic frame_marker_pulse,
    input wire logic vocoder_task_start,
    input wire logic silence_detect_line,
    input wire logic vocoder_run_line,
    input wire logic truncate_request_line,
    input wire logic [3:0] control_nibble_field,
    input wire logic term_cmd_valid,
    input wire logic term_silence_detect,
    input wire logic term_vocoder_run,
    input wire logic term_truncate,
    input wire logic [3:0] term_control,
    input wire logic vector_exact_test,
    output logic silence_detect_enable,
    output logic vocoder_run,
    output logic [3:0] vocoder_control,
    output logic truncated_timing,
    output logic active_control,
    output op_mode_t op_mode,
    output logic rate_converter_enable,
    output logic linear_timing_source,
    output logic [8:0] frame_length
);
    initial begin
        if (SW != 16)
            $error("mixer sample width must be 16");
        if (PW < 1)
            $error("packet width must be positive");
    end

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    localparam int NS = 14;
    logic [NS-1:0] sync1, sync2;
    wire logic [NS-1:0] pins = {mode_select_switch_a, mode_select_switch_b,
        linear_port_select_switch, truncate_switch, frame_marker_pulse,
        silence_detect_line, vocoder_run_line, truncate_request_line,
        control_nibble_field, vector_exact_test, 1'b0};
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {sync1, sync2} <= '0;
        end else if (ce) begin
            sync1 <= pins;
            sync2 <= sync1;
        end
    end
    wire logic s_sw_a = sync2[13];
    wire logic s_sw_b = sync2[12];
    wire logic s_lin_sel = sync2[11];
    wire logic s_trunc_sw = sync2[10];
    wire logic s_marker = sync2[9];
    wire logic s_sil = sync2[8];
    wire logic s_run = sync2[7];
    wire logic s_trq = sync2[6];
    wire logic [3:0] s_nib = sync2[5:2];
    wire logic s_vex = sync2[1];

    // ****************************************************************
    // Mode selection, latched after reset release
    // ****************************************************************
    logic [2:0] strap_wait;
    logic strapped, lin_sel;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {strap_wait, strapped, lin_sel} <= '0;
            op_mode <= MODE_STD;
        end else if (ce && !strapped) begin
            // Wait for synchronisers to fill before sampling straps
            strap_wait <= strap_wait + 3'h1;
            if (strap_wait == 3'h3) begin
                strapped <= 1'b1;
                op_mode <= op_mode_t'(4'h1 << {s_sw_a, s_sw_b});
                lin_sel <= s_lin_sel;
            end
        end
    end
    wire logic is_legacy = (op_mode == MODE_LEGACY);
    wire logic is_alone = (op_mode == MODE_STANDALONE);
    wire logic is_test = (op_mode == MODE_TEST);

    // ****************************************************************
    // Effective configuration
    // ****************************************************************
    // Forced path: vocoder linear partner is analog or PCM
    wire logic [2:0] lin_port = (is_legacy && lin_sel) ? 3'(P_PCM) :
        3'(P_ANALOG);
    wire logic forced = is_legacy || is_alone;
    logic [15:0] weight [5][5];
    genvar go, gi;
    generate
        for (go = 0; go < 5; go++) begin : g_wo
            for (gi = 0; gi < 5; gi++) begin : g_wi
                // Forced unity only on partner<->vocoder paths
                wire logic fpath = (go == int'(P_VOC) &&
                    3'(gi) == lin_port) || (3'(go) == lin_port &&
                    gi == int'(P_VOC));
                assign weight[go][gi] = forced ?
                    (fpath ? `W_UNITY : `W_OFF) :
                    stored_weights[(go*5+gi)*16 +: 16];
            end
        end
    endgenerate
    wire logic [1:0] route_voc = is_legacy ? RT_LINK :
        is_alone ? RT_VOC : stored_routes[1:0];
    wire logic [1:0] route_link = is_legacy ? RT_VOC :
        is_alone ? RT_LINK : stored_routes[3:2];
    wire logic [1:0] route_comm = forced ? RT_OFF : stored_routes[5:4];
    assign rate_converter_enable = forced ? 1'b0 :
        stored_rate_converter_enable;
    assign linear_timing_source = is_legacy ? lin_sel :
        stored_linear_timing_source;
    assign frame_length = is_legacy ? `FRAME_LEN_FORCED :
        (truncated_timing ? stored_frame_length_trunc :
        stored_frame_length_standard_mode);

    // ****************************************************************
    // Linear mixer
    // ****************************************************************
    logic signed [15:0] rx [5], sum_sat [5];
    logic [5*16-1:0] next_tx;
    generate
        for (go = 0; go < 5; go++) begin : g_rx
            assign rx[go] = mix_rx[go*16 +: 16];
        end
        for (go = 0; go < 5; go++) begin : g_mix
            logic signed [35:0] acc;
            always_comb begin
                acc = '0;
                for (int i = 0; i < 5; i++) begin
                    // Own input never feeds own output
                    if (i != go)
                        acc = acc + 36'(($signed(rx[i]) *
                            $signed(weight[go][i])) >>> 15);
                end
            end
            assign sum_sat[go] = (acc > 36'sd32767) ? `SAMPLE_MAX :
                (acc < -36'sd32768) ? `SAMPLE_MIN : acc[15:0];
            // Tone output dead-ends
            assign next_tx[go*16 +: 16] = (go == int'(P_TONE)) ?
                16'h0000 : sum_sat[go];
        end
    endgenerate
    wire logic mix_go = ce && sample_strobe && analog_fifo_ready;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {mix_tx, mix_valid} <= '0;
        end else if (ce) begin
            mix_valid <= mix_go;
            if (mix_go)
                mix_tx <= next_tx;
        end
    end
    sample_fifo #(
        .WIDTH(16),
        .DEPTH(`FIFO_DEPTH)
    ) u_analog_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .in_valid(mix_valid),
        .in_ready(analog_fifo_ready),
        .in_data(mix_tx[int'(P_ANALOG)*16 +: 16]),
        .out_valid(analog_out_valid),
        .out_ready(analog_out_ready),
        .out_data(analog_out_data)
    );

    // ****************************************************************
    // Packet router: one source per output
    // ****************************************************************
    function automatic logic [PW-1:0] rsel(input logic [1:0] s,
        input logic [PW-1:0] v, input logic [PW-1:0] l,
        input logic [PW-1:0] c);
        unique case (s)
            RT_OFF: rsel = '0;
            RT_VOC: rsel = v;
            RT_LINK: rsel = l;
            RT_COMM: rsel = c;
        endcase
    endfunction : rsel
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {pkt_out_voc, pkt_out_link, pkt_out_comm} <= '0;
        end else if (ce) begin
            pkt_out_voc <= rsel(route_voc, pkt_in_voc, pkt_in_link,
                pkt_in_comm);
            pkt_out_link <= rsel(route_link, pkt_in_voc, pkt_in_link,
                pkt_in_comm);
            pkt_out_comm <= rsel(route_comm, pkt_in_voc, pkt_in_link,
                pkt_in_comm);
        end
    end

    // ****************************************************************
    // Vocoder control capture
    // ****************************************************************
    logic marker_d, trq_d, cap_valid, cap_sil, cap_run;
    logic [3:0] cap_nib;
    wire logic marker_rise = s_marker && !marker_d;
    wire logic ext_ok = strapped && !is_test;
    wire logic trq_edge = strapped && is_alone && (s_trq != trq_d);
    assign active_control = !s_vex;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {marker_d, trq_d, cap_valid, cap_sil, cap_run, cap_nib} <= '0;
            {silence_detect_enable, vocoder_run, vocoder_control} <= '0;
            truncated_timing <= 1'b0;
        end else if (ce) begin
            marker_d <= s_marker;
            trq_d <= s_trq;
            if (strap_wait == 3'h3 && !strapped)
                truncated_timing <= s_trunc_sw;
            else if (term_cmd_valid)
                truncated_timing <= term_truncate;
            else if (trq_edge)
                truncated_timing <= !truncated_timing;
            if (marker_rise && ext_ok) begin
                cap_valid <= 1'b1;
                cap_sil <= s_sil;
                cap_run <= s_run;
                cap_nib <= s_nib;
            end else if (vocoder_task_start)
                cap_valid <= 1'b0;
            if (term_cmd_valid) begin
                silence_detect_enable <= term_silence_detect;
                vocoder_run <= term_vocoder_run;
                vocoder_control <= term_control;
            end else if (vocoder_task_start && cap_valid &&
                active_control) begin
                silence_detect_enable <= cap_sil;
                vocoder_run <= cap_run;
                vocoder_control <= cap_nib;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence term_cmd_s;
        ce && term_cmd_valid;
    endsequence
    sequence apply_s;
        ce && !term_cmd_valid && vocoder_task_start && cap_valid &&
            active_control;
    endsequence
    term_immediate_a: assert property (@(posedge clk_sys) disable iff (rst)
        term_cmd_s |=> vocoder_control == $past(term_control))
        else $error("terminal control not applied at once");
    capture_apply_a: assert property (@(posedge clk_sys) disable iff (rst)
        apply_s |=> vocoder_control == $past(cap_nib))
        else $error("captured control not applied at task start");
    test_ignore_a: assert property (@(posedge clk_sys) disable iff (rst)
        (is_test && strapped && ce && !term_cmd_valid) |=>
        $stable(vocoder_control))
        else $error("external control acted in test mode");
    legacy_weight_a: assert property (@(posedge clk_sys) disable iff (rst)
        is_legacy |-> weight[P_VOC][lin_port] == `W_UNITY &&
        weight[P_COMM][P_VOC] == `W_OFF)
        else $error("legacy weights not forced");
    alone_loop_a: assert property (@(posedge clk_sys) disable iff (rst)
        (is_alone && ce) |=> pkt_out_voc == $past(pkt_in_voc) &&
        pkt_out_link == $past(pkt_in_link))
        else $error("standalone loopback broken");
    tone_dead_a: assert property (@(posedge clk_sys) disable iff (rst)
        mix_tx[int'(P_TONE)*16 +: 16] == 16'h0000)
        else $error("tone output driven");
    trunc_toggle_a: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && trq_edge && !term_cmd_valid && strapped) |=>
        truncated_timing != $past(truncated_timing))
        else $error("truncate request change missed");
    std_mode_a: assert property (@(posedge clk_sys) disable iff (rst)
        (op_mode == MODE_STD) |-> frame_length == (truncated_timing ?
        stored_frame_length_trunc : stored_frame_length_standard_mode))
        else $error("standard mode not using stored settings");
endmodule : voice_mode_mixer_router
`default_nettype wire

// ### tb/codec_sink.sv
// Analog codec side model: drains the analog output FIFO, can stall
`timescale 1ns/1ps
`default_nettype none
module codec_sink (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic stall,
    input wire logic valid,
    output logic ready,
    input wire logic [15:0] data
);
    logic [15:0] got [0:15];
    int n_got;
    // Ready only moves after an edge, so a word is never half taken
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ready <= 1'b0;
            n_got <= 0;
        end else begin
            ready <= !stall;
            if (valid && ready) begin
                got[n_got[3:0]] <= data;
                n_got <= n_got + 1;
            end
        end
    end
endmodule : codec_sink
`default_nettype wire

// ### tb/voice_mode_mixer_router_tb_top.sv
// Self-checking bench for the voice mode mixer and packet router
`timescale 1ns/1ps
`default_nettype none
module voice_mode_mixer_router_tb_top import voice_flow_pkg::*;;
    logic clk_sys, rst, ce, mode_select_switch_a, mode_select_switch_b;
    logic linear_port_select_switch, truncate_switch, sample_strobe;
    logic stored_rate_converter_enable, stored_linear_timing_source;
    logic analog_out_ready, frame_marker_pulse, vocoder_task_start;
    logic silence_detect_line, vocoder_run_line, truncate_request_line;
    logic term_cmd_valid, term_silence_detect, term_vocoder_run;
    logic term_truncate, vector_exact_test, stall, mix_valid;
    logic analog_out_valid, analog_fifo_ready, silence_detect_enable;
    logic vocoder_run, truncated_timing, active_control;
    logic rate_converter_enable, linear_timing_source;
    logic [399:0] stored_weights;
    logic [5:0] stored_routes;
    logic [8:0] stored_frame_length_standard_mode, stored_frame_length_trunc;
    logic [8:0] frame_length;
    logic [79:0] mix_rx, mix_tx;
    logic [15:0] analog_out_data;
    logic [7:0] pkt_in_voc, pkt_in_link, pkt_in_comm;
    logic [7:0] pkt_out_voc, pkt_out_link, pkt_out_comm;
    logic [3:0] control_nibble_field, term_control, vocoder_control;
    op_mode_t op_mode;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    int n_mixv = 0;
    int base, m;
    // Port samples {comm, tone, voc, pcm, analog}
    localparam logic [79:0] RX_MIX =
        {16'h0800, 16'h0400, 16'h2000, 16'h1000, 16'h4000};
    typedef struct { logic [15:0] w; logic [15:0] rx; logic [15:0] e; } row_t;
    row_t rows [5] = '{'{16'h7FFF, 16'h1000, 16'h3FFC},
        '{16'h7FFF, 16'h4000, 16'h7FFF}, '{16'h7FFF, 16'hC000, 16'h8000},
        '{16'h0000, 16'h1234, 16'h0000}, '{16'h4000, 16'h0100, 16'h0200}};

    voice_mode_mixer_router u_voice_mode_mixer_router (.clk_sys, .rst, .ce,
        .mode_select_switch_a, .mode_select_switch_b,
        .linear_port_select_switch, .truncate_switch, .stored_weights,
        .stored_routes, .stored_rate_converter_enable,
        .stored_linear_timing_source, .stored_frame_length_standard_mode,
        .stored_frame_length_trunc, .mix_rx, .sample_strobe, .mix_tx,
        .mix_valid, .analog_out_valid, .analog_out_ready, .analog_out_data,
        .analog_fifo_ready, .pkt_in_voc, .pkt_in_link, .pkt_in_comm,
        .pkt_out_voc, .pkt_out_link, .pkt_out_comm, .frame_marker_pulse,
        .vocoder_task_start, .silence_detect_line, .vocoder_run_line,
        .truncate_request_line, .control_nibble_field, .term_cmd_valid,
        .term_silence_detect, .term_vocoder_run, .term_truncate,
        .term_control, .vector_exact_test, .silence_detect_enable,
        .vocoder_run, .vocoder_control, .truncated_timing, .active_control,
        .op_mode, .rate_converter_enable, .linear_timing_source,
        .frame_length);
    codec_sink u_codec_sink (.clk_sys, .rst, .stall,
        .valid(analog_out_valid), .ready(analog_out_ready),
        .data(analog_out_data));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (mix_valid === 1'b1) n_mixv <= n_mixv + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task chk(input logic [79:0] seen, input logic [79:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    // Straps are only read after reset, so every mode needs its own reset
    task do_reset(input logic a, input logic b, input logic sel);
        @(posedge clk_sys);
        rst <= 1'b1;
        mode_select_switch_a <= a;
        mode_select_switch_b <= b;
        linear_port_select_switch <= sel;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : do_reset
    task strobe;
        @(posedge clk_sys);
        sample_strobe <= 1'b1;
        @(posedge clk_sys);
        sample_strobe <= 1'b0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : strobe
    task marker;
        @(posedge clk_sys);
        frame_marker_pulse <= 1'b1;
        repeat (3) @(posedge clk_sys);
        frame_marker_pulse <= 1'b0;
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : marker
    task task_start;
        @(posedge clk_sys);
        vocoder_task_start <= 1'b1;
        @(posedge clk_sys);
        vocoder_task_start <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : task_start
    task lines(input logic s, input logic r, input logic [3:0] n);
        @(posedge clk_sys);
        silence_detect_line <= s;
        vocoder_run_line <= r;
        control_nibble_field <= n;
    endtask : lines
    task mode_check(input logic a, input logic b, input logic sel,
            input op_mode_t md, input logic [79:0] etx,
            input logic [23:0] epkt, input logic [10:0] etim);
        do_reset(a, b, sel);
        chk(80'(op_mode), 80'(md));
        @(posedge clk_sys);
        stored_weights <= {25{16'h7FFF}};
        mix_rx <= RX_MIX;
        strobe();
        chk(mix_tx, etx);
        chk(80'({pkt_out_voc, pkt_out_link, pkt_out_comm}), 80'(epkt));
        chk(80'({rate_converter_enable, linear_timing_source, frame_length}),
            80'(etim));
        $display("done: mode %h", md);
    endtask : mode_check

    initial begin
        {rst, ce, mode_select_switch_a, mode_select_switch_b} <= 4'hC;
        {linear_port_select_switch, truncate_switch, sample_strobe} <= 3'h0;
        {frame_marker_pulse, vocoder_task_start, stall} <= 3'h0;
        {silence_detect_line, vocoder_run_line, truncate_request_line} <= 3'h0;
        {term_cmd_valid, term_silence_detect, term_vocoder_run} <= 3'h0;
        {term_truncate, vector_exact_test} <= 2'h0;
        {control_nibble_field, term_control} <= 8'h00;
        {stored_rate_converter_enable, stored_linear_timing_source} <= 2'h3;
        stored_frame_length_standard_mode <= 9'h0A0;
        stored_frame_length_trunc <= 9'h0E6;
        stored_weights <= 400'h0;
        stored_routes <= 6'h27;
        mix_rx <= 80'h0;
        {pkt_in_voc, pkt_in_link, pkt_in_comm} <= 24'hA1B2C3;
        do_reset(1'b0, 1'b0, 1'b0);
        chk(80'(op_mode), 80'(MODE_STD));
        chk(80'({silence_detect_enable, vocoder_run, vocoder_control,
            truncated_timing, active_control}), 80'h01);
        chk(80'({rate_converter_enable, linear_timing_source, frame_length}),
            80'h6A0);
        chk(80'({pkt_out_voc, pkt_out_link, pkt_out_comm}), 80'hC3A1B2);
        foreach (rows[k]) begin
            @(posedge clk_sys);
            stored_weights <= {25{rows[k].w}};
            mix_rx <= {5{rows[k].rx}};
            strobe();
            chk(mix_tx, {rows[k].e, 16'h0000, {3{rows[k].e}}});
        end
        $display("done: mixer rows");
        // Only weight(out analog, in voc): a swapped index shows elsewhere
        @(posedge clk_sys);
        stored_weights <= 400'h0 | (400'h7FFF << 32);
        mix_rx <= RX_MIX;
        strobe();
        chk(mix_tx, {64'h0, 16'h1FFF});
        @(posedge clk_sys);
        stall <= 1'b1;
        stored_weights <= {25{16'h7FFF}};
        repeat (3) @(posedge clk_sys);
        base = u_codec_sink.n_got;
        for (int k = 1; k <= 4; k++) begin
            mix_rx <= {5{16'(k * 256)}};
            strobe();
        end
        repeat (2) @(negedge clk_sys);
        chk(80'(analog_fifo_ready), 80'h0);
        m = n_mixv;
        strobe();
        chk(80'(n_mixv - m), 80'h0);
        @(posedge clk_sys);
        stall <= 1'b0;
        repeat (12) @(negedge clk_sys);
        chk(80'(u_codec_sink.n_got - base), 80'h4);
        for (int k = 1; k <= 4; k++)
            chk(80'(u_codec_sink.got[(base + k - 1) % 16]),
                80'(16'(k * 16'h0400 - 4)));
        chk(80'(analog_out_valid), 80'h0);
        $display("done: fifo");
        lines(1'b1, 1'b1, 4'hA);
        repeat (4) @(posedge clk_sys);
        marker();
        chk(80'({silence_detect_enable, vocoder_run, vocoder_control}),
            80'h00);
        task_start();
        chk(80'({silence_detect_enable, vocoder_run, vocoder_control}),
            80'h3A);
        @(posedge clk_sys);
        vector_exact_test <= 1'b1;
        lines(1'b0, 1'b0, 4'h5);
        repeat (5) @(negedge clk_sys);
        chk(80'(active_control), 80'h0);
        marker();
        task_start();
        chk(80'({silence_detect_enable, vocoder_run, vocoder_control}),
            80'h3A);
        @(posedge clk_sys);
        vector_exact_test <= 1'b0;
        repeat (5) @(posedge clk_sys);
        {term_cmd_valid, term_silence_detect, term_vocoder_run} <= 3'h5;
        {term_truncate, term_control} <= 5'h13;
        @(posedge clk_sys);
        term_cmd_valid <= 1'b0;
        @(negedge clk_sys);
        chk(80'({silence_detect_enable, vocoder_run, vocoder_control,
            truncated_timing}), 80'h27);
        $display("done: vocoder control");
        mode_check(1'b0, 1'b1, 1'b0, MODE_LEGACY, {32'h0, 16'h3FFF,
            16'h0, 16'h1FFF}, 24'hB2A100, 11'h0C0);
        mode_check(1'b0, 1'b1, 1'b1, MODE_LEGACY, {32'h0, 16'h0FFF,
            16'h1FFF, 16'h0}, 24'hB2A100, 11'h2C0);
        mode_check(1'b1, 1'b0, 1'b0, MODE_STANDALONE, {32'h0, 16'h3FFF,
            16'h0, 16'h1FFF}, 24'hA1B200, 11'h2A0);
        for (int k = 1; k <= 2; k++) begin
            @(posedge clk_sys);
            truncate_request_line <= !truncate_request_line;
            repeat (8) @(negedge clk_sys);
            chk(80'(truncated_timing), 80'(k % 2));
        end
        mode_check(1'b1, 1'b1, 1'b0, MODE_TEST, {16'h73FC, 16'h0, 16'h5BFC,
            16'h6BFC, 16'h3BFC}, 24'hC3A1B2, 11'h6A0);
        lines(1'b1, 1'b1, 4'hF);
        @(posedge clk_sys);
        truncate_request_line <= !truncate_request_line;
        marker();
        task_start();
        chk(80'({silence_detect_enable, vocoder_run, vocoder_control,
            truncated_timing}), 80'h00);
        $display("done: test mode");
        end_of_test();
    end
endmodule : voice_mode_mixer_router_tb_top
`default_nettype wire
